//--- aaeu_defines.vh
// constants for the add and absolute-value execute unit
`ifndef AAEU_DEFINES_VH
`define AAEU_DEFINES_VH

// instruction field positions
`define AAEU_F_OP        31:26
`define AAEU_F_RS        25:21
`define AAEU_F_RT        20:16
`define AAEU_F_RD        15:11
`define AAEU_F_SHAMT     10:6
`define AAEU_F_FUNCT     5:0
`define AAEU_F_FMT       25:21
`define AAEU_F_FT        20:16
`define AAEU_F_FS        15:11
`define AAEU_F_FD        10:6
`define AAEU_F_IMM16     15:0
`define AAEU_F_IMM19     18:0
`define AAEU_F_PCSUB     20:19

// major opcodes and function codes
`define AAEU_OP_REGISTER 6'h00
`define AAEU_OP_IMM_TRAP 6'h08
`define AAEU_OP_IMM_MOD  6'h09
`define AAEU_OP_FLOAT    6'h11
`define AAEU_OP_PC_RELATIVE_MAJOR_OPCODE    6'h3B
`define AAEU_FN_REG_ADD  6'h20
`define AAEU_FN_FADD     6'h00
`define AAEU_FN_FABS     6'h05
`define AAEU_PCSUB_ADD   2'h0
`define AAEU_SHAMT_ZERO  5'h00
`define AAEU_FT_ZERO     5'h00

// float formats
`define AAEU_FMT_SINGLE  5'h10
`define AAEU_FMT_DOUBLE  5'h11
`define AAEU_FMT_PAIRED  5'h16

// rounding modes
`define AAEU_RM_NEAREST  2'h0
`define AAEU_RM_ZERO     2'h1
`define AAEU_RM_PLUS     2'h2
`define AAEU_RM_MINUS    2'h3

// cause bit positions; flags use bits 4..0 only
`define AAEU_C_INEXACT   0
`define AAEU_C_UNDER     1
`define AAEU_C_OVER      2
`define AAEU_C_DIVZ      3
`define AAEU_C_INVALID   4
`define AAEU_C_UNIMPL    5

// exception codes to the pipeline
`define AAEU_EXC_NONE    3'h0
`define AAEU_EXC_INT_OVF 3'h1
`define AAEU_EXC_RESERVD 3'h2
`define AAEU_EXC_COP_UNU 3'h3
`define AAEU_EXC_FLOAT   3'h4

// reset values
`define AAEU_CAUSE_RST   6'h00
`define AAEU_FLAGS_RST   5'h00

`endif

//--- aaeu_fp_abs.v
// floating absolute value, arithmetic or sign-only
`timescale 1ns/1ps
`default_nettype none
`include "aaeu_defines.vh"

module aaeu_fp_abs #(
    parameter EW = 8,
    parameter MW = 23
) (
    // operand and mode
    input  wire [EW+MW:0] i_val,
    input  wire           i_nonarith,
    // result
    output wire [EW+MW:0] o_res,
    output wire [5:0]     o_cause
);
    wire is_nan;

    assign is_nan = (&i_val[EW+MW-1:MW]) & (|i_val[MW-1:0]);
    // sign clear is the same either way; only the exception differs
    assign o_res  = {1'b0, i_val[EW+MW-1:0]};
    assign o_cause = {1'b0, is_nan & ~i_nonarith, 4'h0};
endmodule // aaeu_fp_abs

`default_nettype wire

//--- aaeu_fp_add.v
// combinational ieee adder with four rounding modes
`timescale 1ns/1ps
`default_nettype none
`include "aaeu_defines.vh"

module aaeu_fp_add #(
    parameter EW = 8,
    parameter MW = 23
) (
    // operands and rounding mode
    input  wire [EW+MW:0] i_a,
    input  wire [EW+MW:0] i_b,
    input  wire [1:0]     i_rmode,
    // rounded sum and cause bits
    output reg  [EW+MW:0] o_sum,
    output reg  [5:0]     o_cause
);
    localparam M = MW + 4;
    localparam [EW-1:0] EMAX = {EW{1'b1}};

    reg [EW+MW:0] x;
    reg [EW+MW:0] y;
    reg [M-1:0]   my;
    reg [M-1:0]   sh;
    reg [M:0]     s;
    reg [EW+1:0]  e;
    reg [MW+1:0]  r;
    reg           nan_a;
    reg           nan_b;
    reg           inx;
    reg           inc;
    reg           neg;
    integer       d;
    integer       i;

    always @* begin
        x = i_a;
        y = i_b;
        my = {M{1'b0}};
        sh = {M{1'b0}};
        s = {(M+1){1'b0}};
        e = {(EW+2){1'b0}};
        r = {(MW+2){1'b0}};
        inx = 1'b0;
        inc = 1'b0;
        neg = 1'b0;
        d = 0;
        o_cause = 6'h00;
        nan_a = (i_a[EW+MW-1:MW] == EMAX) && (|i_a[MW-1:0]);
        nan_b = (i_b[EW+MW-1:MW] == EMAX) && (|i_b[MW-1:0]);
        o_sum = {1'b0, EMAX, 1'b1, {(MW-1){1'b0}}};
        if (nan_a || nan_b) begin
            // signalling nans have the quiet bit clear
            o_cause[`AAEU_C_INVALID] = (nan_a & ~i_a[MW-1]) | (nan_b & ~i_b[MW-1]);
        end else if ((i_a[EW+MW-1:0] == {EMAX, {MW{1'b0}}}) && (i_b[EW+MW-1:0] == {EMAX, {MW{1'b0}}})
                     && (i_a[EW+MW] != i_b[EW+MW])) begin
            o_cause[`AAEU_C_INVALID] = 1'b1;
        end else if (i_a[EW+MW-1:MW] == EMAX) begin
            o_sum = i_a;
        end else if (i_b[EW+MW-1:MW] == EMAX) begin
            o_sum = i_b;
        end else begin
            if (i_b[EW+MW-1:0] > i_a[EW+MW-1:0]) begin
                x = i_b;
                y = i_a;
            end
            d = ((x[EW+MW-1:MW] == 0) ? 1 : x[EW+MW-1:MW]) - ((y[EW+MW-1:MW] == 0) ? 1 : y[EW+MW-1:MW]);
            my = {|y[EW+MW-1:MW], y[MW-1:0], 3'h0};
            if (d >= M) begin
                sh = {{(M-1){1'b0}}, |my};
            end else begin
                sh = my >> d;
                sh[0] = sh[0] | (|(my & ~({M{1'b1}} << d)));
            end
            if (x[EW+MW] == y[EW+MW])
                s = {1'b0, |x[EW+MW-1:MW], x[MW-1:0], 3'h0} + {1'b0, sh};
            else
                s = {1'b0, |x[EW+MW-1:MW], x[MW-1:0], 3'h0} - {1'b0, sh};
            e = (x[EW+MW-1:MW] == 0) ? {{(EW+1){1'b0}}, 1'b1} : {2'h0, x[EW+MW-1:MW]};
            if (s == 0) begin
                neg = (x[EW+MW] == y[EW+MW]) ? x[EW+MW] : (i_rmode == `AAEU_RM_MINUS);
                o_sum = {neg, {(EW+MW){1'b0}}};
            end else begin
                if (s[M]) begin
                    s = {1'b0, s[M:2], s[1] | s[0]};
                    e = e + 1'b1;
                end
                // denormal results stop normalising at the minimum exponent
                for (i = 0; i < M; i = i + 1) begin
                    if (!s[M-1] && (e > 1)) begin
                        s = {s[M-1:0], 1'b0};
                        e = e - 1'b1;
                    end
                end
                inx = |s[2:0];
                case (i_rmode)
                    `AAEU_RM_NEAREST: inc = s[2] & ((|s[1:0]) | s[3]);
                    `AAEU_RM_PLUS:    inc = inx & ~x[EW+MW];
                    `AAEU_RM_MINUS:   inc = inx & x[EW+MW];
                    default:          inc = 1'b0;
                endcase
                r = {1'b0, s[M-1:3]} + {{(MW+1){1'b0}}, inc};
                if (r[MW+1]) begin
                    r = {1'b0, r[MW+1:1]};
                    e = e + 1'b1;
                end
                o_cause[`AAEU_C_INEXACT] = inx;
                o_cause[`AAEU_C_UNDER] = inx & ~r[MW];
                if (e >= {2'h0, EMAX}) begin
                    o_cause[`AAEU_C_OVER] = 1'b1;
                    o_cause[`AAEU_C_INEXACT] = 1'b1;
                    if ((i_rmode == `AAEU_RM_NEAREST) || ((i_rmode == `AAEU_RM_PLUS) && !x[EW+MW])
                        || ((i_rmode == `AAEU_RM_MINUS) && x[EW+MW]))
                        o_sum = {x[EW+MW], EMAX, {MW{1'b0}}};
                    else
                        o_sum = {x[EW+MW], EMAX - 1'b1, {MW{1'b1}}};
                end else begin
                    o_sum = {x[EW+MW], r[MW] ? e[EW-1:0] : {EW{1'b0}}, r[MW-1:0]};
                end
            end
        end
    end
endmodule // aaeu_fp_add

`default_nettype wire

//--- aaeu_exec.v
// add-class execute unit: integer adds, pc-relative add, float add and abs
`timescale 1ns/1ps
`default_nettype none
`include "aaeu_defines.vh"

module aaeu_exec #(
    parameter HAS_PAIRED = 1
) (
    // clock, reset, enable
    input  wire        i_clk,
    input  wire        i_arst_n,
    input  wire        i_ce,
    // issued instruction and operands
    input  wire        i_issue,
    input  wire [31:0] i_instr,
    input  wire [31:0] i_pc,
    input  wire [31:0] i_src_a,
    input  wire [31:0] i_src_b,
    input  wire [63:0] i_fsrc_a,
    input  wire [63:0] i_fsrc_b,
    // configuration
    input  wire        i_release6,
    input  wire        i_fpu_enable,
    input  wire        i_float_register_model,
    input  wire        i_ieee2008_capability,
    input  wire        i_abs_nonarith_control,
    input  wire [1:0]  i_round_mode,
    input  wire [4:0]  i_fp_trap_enable,
    // software write of the sticky flags
    input  wire        i_flags_wr,
    input  wire [4:0]  i_flags_data,
    // general register result
    output reg         o_gr_we,
    output reg  [4:0]  o_gr_idx,
    output reg  [31:0] o_gr_data,
    // float register result
    output reg         o_fr_we,
    output reg  [4:0]  o_fr_idx,
    output reg  [63:0] o_fr_data,
    // completion and exceptions
    output reg         o_done,
    output reg  [2:0]  o_exc,
    output reg  [5:0]  o_cause,
    output reg  [4:0]  o_flags
);
    function [32:0] aaeu_add33(input [31:0] a, input [31:0] b);
        aaeu_add33 = {a[31], a} + {b[31], b};
    endfunction

    function aaeu_ovf(input [32:0] t);
        aaeu_ovf = t[32] ^ t[31];
    endfunction

    function [31:0] aaeu_sext16(input [15:0] v);
        aaeu_sext16 = {{16{v[15]}}, v};
    endfunction

    // instruction fields
    wire [5:0]  op;
    wire [5:0]  funct;
    wire [4:0]  fmt;
    wire [31:0] imm_ext;
    wire [31:0] pc_off;
    wire [32:0] sum_reg;
    wire [32:0] sum_imm;
    wire [31:0] sum_pc;

    assign op      = i_instr[`AAEU_F_OP];
    assign funct   = i_instr[`AAEU_F_FUNCT];
    assign fmt     = i_instr[`AAEU_F_FMT];
    assign imm_ext = aaeu_sext16(i_instr[`AAEU_F_IMM16]);
    assign pc_off  = {{11{i_instr[18]}}, i_instr[`AAEU_F_IMM19], 2'h0};
    assign sum_reg = aaeu_add33(i_src_a, i_src_b);
    assign sum_imm = aaeu_add33(i_src_a, imm_ext);
    assign sum_pc  = i_pc + pc_off;

    // float datapaths: low single, high single, double
    wire [31:0] add_lo;
    wire [31:0] add_hi;
    wire [63:0] add_dbl;
    wire [5:0]  add_lo_c;
    wire [5:0]  add_hi_c;
    wire [5:0]  add_dbl_c;
    wire [31:0] abs_lo;
    wire [31:0] abs_hi;
    wire [63:0] abs_dbl;
    wire [5:0]  abs_lo_c;
    wire [5:0]  abs_hi_c;
    wire [5:0]  abs_dbl_c;
    wire        nonarith;

    // the control only takes effect on a unit that advertises 2008 support
    assign nonarith = i_ieee2008_capability & i_abs_nonarith_control;

    aaeu_fp_add #(.EW(8), .MW(23)) u_add_lo (
        .i_a     (i_fsrc_a[31:0]),
        .i_b     (i_fsrc_b[31:0]),
        .i_rmode (i_round_mode),
        .o_sum   (add_lo),
        .o_cause (add_lo_c)
    );

    aaeu_fp_add #(.EW(8), .MW(23)) u_add_hi (
        .i_a     (i_fsrc_a[63:32]),
        .i_b     (i_fsrc_b[63:32]),
        .i_rmode (i_round_mode),
        .o_sum   (add_hi),
        .o_cause (add_hi_c)
    );

    aaeu_fp_add #(.EW(11), .MW(52)) u_add_dbl (
        .i_a     (i_fsrc_a),
        .i_b     (i_fsrc_b),
        .i_rmode (i_round_mode),
        .o_sum   (add_dbl),
        .o_cause (add_dbl_c)
    );

    aaeu_fp_abs #(.EW(8), .MW(23)) u_abs_lo (
        .i_val      (i_fsrc_a[31:0]),
        .i_nonarith (nonarith),
        .o_res      (abs_lo),
        .o_cause    (abs_lo_c)
    );

    aaeu_fp_abs #(.EW(8), .MW(23)) u_abs_hi (
        .i_val      (i_fsrc_a[63:32]),
        .i_nonarith (nonarith),
        .o_res      (abs_hi),
        .o_cause    (abs_hi_c)
    );

    aaeu_fp_abs #(.EW(11), .MW(52)) u_abs_dbl (
        .i_val      (i_fsrc_a),
        .i_nonarith (nonarith),
        .o_res      (abs_dbl),
        .o_cause    (abs_dbl_c)
    );

    // float decode
    wire is_fadd;
    wire is_fabs;
    wire fmt_s;
    wire fmt_d;
    wire fmt_ps;
    wire fmt_ok;
    wire ps_undef;

    assign is_fadd  = (funct == `AAEU_FN_FADD);
    assign is_fabs  = (funct == `AAEU_FN_FABS) && (i_instr[`AAEU_F_FT] == `AAEU_FT_ZERO);
    assign fmt_s    = (fmt == `AAEU_FMT_SINGLE);
    assign fmt_d    = (fmt == `AAEU_FMT_DOUBLE);
    assign fmt_ps   = (fmt == `AAEU_FMT_PAIRED) && (HAS_PAIRED != 0) && !i_release6;
    assign fmt_ok   = fmt_s | fmt_d | fmt_ps;
    // paired forms outside the 64-bit model trap as unimplemented rather than guess
    assign ps_undef = fmt_ps & ~i_float_register_model;

    // float result and cause per format
    reg [63:0] f_res;
    reg [5:0]  f_cause;

    always @* begin
        f_res = 64'h0000000000000000;
        f_cause = 6'h00;
        if (is_fadd) begin
            if (fmt_d) begin
                f_res = add_dbl;
                f_cause = add_dbl_c;
            end else if (fmt_ps) begin
                f_res = {add_hi, add_lo};
                f_cause = add_hi_c | add_lo_c;
            end else begin
                f_res = {32'h00000000, add_lo};
                f_cause = add_lo_c;
            end
        end else begin
            if (fmt_d) begin
                f_res = abs_dbl;
                f_cause = abs_dbl_c;
            end else if (fmt_ps) begin
                f_res = {abs_hi, abs_lo};
                f_cause = abs_hi_c | abs_lo_c;
            end else begin
                f_res = {32'h00000000, abs_lo};
                f_cause = abs_lo_c;
            end
        end
        if (ps_undef) begin
            f_res = 64'h0000000000000000;
            f_cause = 6'h00;
            f_cause[`AAEU_C_UNIMPL] = 1'b1;
        end
    end

    // unimplemented always traps; others trap only where enabled
    wire f_trap;

    assign f_trap = f_cause[`AAEU_C_UNIMPL] | (|(f_cause[4:0] & i_fp_trap_enable));

    // next state
    reg         next_gr_we;
    reg  [4:0]  next_gr_idx;
    reg  [31:0] next_gr_data;
    reg         next_fr_we;
    reg  [4:0]  next_fr_idx;
    reg  [63:0] next_fr_data;
    reg  [2:0]  next_exc;
    reg  [5:0]  next_cause;
    reg  [4:0]  next_flags;

    always @* begin
        next_gr_we = 1'b0;
        next_gr_idx = 5'h00;
        next_gr_data = 32'h00000000;
        next_fr_we = 1'b0;
        next_fr_idx = 5'h00;
        next_fr_data = 64'h0000000000000000;
        next_exc = `AAEU_EXC_NONE;
        next_cause = o_cause;
        next_flags = i_flags_wr ? i_flags_data : o_flags;
        if (i_issue) begin
            case (op)
                `AAEU_OP_REGISTER: begin
                    if ((funct == `AAEU_FN_REG_ADD) &&
                        (i_instr[`AAEU_F_SHAMT] == `AAEU_SHAMT_ZERO)) begin
                        if (aaeu_ovf(sum_reg)) begin
                            next_exc = `AAEU_EXC_INT_OVF;
                        end else begin
                            next_gr_we = 1'b1;
                            next_gr_idx = i_instr[`AAEU_F_RD];
                            next_gr_data = sum_reg[31:0];
                        end
                    end else begin
                        next_exc = `AAEU_EXC_RESERVD;
                    end
                end
                `AAEU_OP_IMM_TRAP: begin
                    if (i_release6) begin
                        next_exc = `AAEU_EXC_RESERVD;
                    end else if (aaeu_ovf(sum_imm)) begin
                        next_exc = `AAEU_EXC_INT_OVF;
                    end else begin
                        next_gr_we = 1'b1;
                        next_gr_idx = i_instr[`AAEU_F_RT];
                        next_gr_data = sum_imm[31:0];
                    end
                end
                `AAEU_OP_IMM_MOD: begin
                    next_gr_we = 1'b1;
                    next_gr_idx = i_instr[`AAEU_F_RT];
                    next_gr_data = sum_imm[31:0];
                end
                `AAEU_OP_PC_RELATIVE_MAJOR_OPCODE: begin
                    if (i_release6 && (i_instr[`AAEU_F_PCSUB] == `AAEU_PCSUB_ADD)) begin
                        next_gr_we = 1'b1;
                        next_gr_idx = i_instr[`AAEU_F_RS];
                        next_gr_data = sum_pc;
                    end else begin
                        next_exc = `AAEU_EXC_RESERVD;
                    end
                end
                `AAEU_OP_FLOAT: begin
                    if (!i_fpu_enable) begin
                        next_exc = `AAEU_EXC_COP_UNU;
                    end else if (!fmt_ok || !(is_fadd || is_fabs)) begin
                        next_exc = `AAEU_EXC_RESERVD;
                    end else if (is_fabs && nonarith && !ps_undef) begin
                        // sign-only move: cause and flags stay as they are
                        next_fr_we = 1'b1;
                        next_fr_idx = i_instr[`AAEU_F_FD];
                        next_fr_data = f_res;
                    end else begin
                        next_cause = f_cause;
                        if (f_trap) begin
                            next_exc = `AAEU_EXC_FLOAT;
                        end else begin
                            next_fr_we = 1'b1;
                            next_fr_idx = i_instr[`AAEU_F_FD];
                            next_fr_data = f_res;
                            next_flags = next_flags | f_cause[4:0];
                        end
                    end
                end
                default: begin
                    next_exc = `AAEU_EXC_RESERVD;
                end
            endcase
        end
    end

    // one result per issue, one cycle later; everything frozen while i_ce is low
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_gr_we <= 1'b0;
            o_gr_idx <= 5'h00;
            o_gr_data <= 32'h00000000;
            o_fr_we <= 1'b0;
            o_fr_idx <= 5'h00;
            o_fr_data <= 64'h0000000000000000;
            o_done <= 1'b0;
            o_exc <= `AAEU_EXC_NONE;
            o_cause <= `AAEU_CAUSE_RST;
            o_flags <= `AAEU_FLAGS_RST;
        end else if (i_ce) begin
            o_gr_we <= next_gr_we;
            o_gr_idx <= next_gr_idx;
            o_gr_data <= next_gr_data;
            o_fr_we <= next_fr_we;
            o_fr_idx <= next_fr_idx;
            o_fr_data <= next_fr_data;
            o_done <= i_issue;
            o_exc <= next_exc;
            o_cause <= next_cause;
            o_flags <= next_flags;
        end
    end
endmodule // aaeu_exec

`default_nettype wire

//--- aaeu_exec_monitor.sv
// concurrent checks on the execute unit ports
`timescale 1ns/1ps
`default_nettype none
`include "aaeu_defines.vh"
module aaeu_exec_monitor (
    // clock, reset, enable, issue, configuration and operands
    input wire        i_clk, i_arst_n, i_ce, i_issue, i_release6, i_fpu_enable, i_flags_wr,
    input wire        i_ieee2008_capability, i_abs_nonarith_control,
    input wire [31:0] i_instr, i_pc, i_src_a, i_src_b,
    // results
    input wire        o_gr_we, o_fr_we, o_done,
    input wire [31:0] o_gr_data,
    input wire [2:0]  o_exc,
    input wire [5:0]  o_cause,
    input wire [4:0]  o_flags
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    wire        tk   = i_ce && i_issue;
    wire [5:0]  op   = i_instr[31:26];
    wire        fop  = op == `AAEU_OP_FLOAT;
    wire [32:0] rsum = {i_src_a[31], i_src_a} + {i_src_b[31], i_src_b};
    wire [31:0] rlo  = rsum[31:0];
    wire [31:0] imod = i_src_a + {{16{i_instr[15]}}, i_instr[15:0]};
    wire [31:0] pcr  = i_pc + {{11{i_instr[18]}}, i_instr[18:0], 2'h0};
    wire        radd = op == `AAEU_OP_REGISTER && i_instr[5:0] == `AAEU_FN_REG_ADD && i_instr[10:6] == 5'h00;
    property p_done; tk |=> o_done; endproperty
    a_done: assert property (p_done) else $error("issue not completed");
    property p_ovf; tk && radd && rsum[32] != rsum[31] |=> o_exc == `AAEU_EXC_INT_OVF && !o_gr_we; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not trapped");
    property p_radd; tk && radd && rsum[32] == rsum[31] |=> o_gr_we && o_gr_data == $past(rlo); endproperty
    a_radd: assert property (p_radd) else $error("register add sum wrong");
    property p_imod; tk && op == `AAEU_OP_IMM_MOD
        |=> o_exc == 3'h0 && o_gr_we && o_gr_data == $past(imod); endproperty
    a_imod: assert property (p_imod) else $error("modulo add wrong");
    property p_pcr; tk && op == `AAEU_OP_PC_RELATIVE_MAJOR_OPCODE && i_instr[20:19] == 2'h0 && i_release6
        |=> o_exc == 3'h0 && o_gr_we && o_gr_data == $past(pcr); endproperty
    a_pcr: assert property (p_pcr) else $error("pc relative add wrong");
    property p_r6; tk && op == `AAEU_OP_IMM_TRAP && i_release6 |=> o_exc == `AAEU_EXC_RESERVD && !o_gr_we; endproperty
    a_r6: assert property (p_r6) else $error("removed add not reserved");
    property p_cop; tk && fop && !i_fpu_enable |=> o_exc == `AAEU_EXC_COP_UNU && !o_fr_we; endproperty
    a_cop: assert property (p_cop) else $error("float unit off not refused");
    property p_trap; o_done && o_exc != 3'h0 |-> !o_gr_we && !o_fr_we; endproperty
    a_trap: assert property (p_trap) else $error("write despite exception");
    property p_flag; i_ce && !i_flags_wr |=> (o_flags & $past(o_flags)) == $past(o_flags); endproperty
    a_flag: assert property (p_flag) else $error("sticky flag lost");
    property p_nab; tk && fop && i_instr[5:0] == `AAEU_FN_FABS && i_ieee2008_capability && i_abs_nonarith_control
        && !i_flags_wr |=> $stable(o_cause) && $stable(o_flags); endproperty
    a_nab: assert property (p_nab) else $error("sign-only abs touched status");
endmodule // aaeu_exec_monitor
`default_nettype wire

//--- aaeu_pipe_model.sv
// pipeline model issuing one instruction per call
`timescale 1ns/1ps
`default_nettype none
module aaeu_pipe_model (
    input  wire logic        i_clk,
    output var  logic        o_issue,
    output var  logic [31:0] o_instr,
    output var  logic [31:0] o_pc,
    output var  logic [31:0] o_a,
    output var  logic [31:0] o_b,
    output var  logic [63:0] o_fa,
    output var  logic [63:0] o_fb
);
    initial {o_issue, o_instr, o_pc, o_a, o_b, o_fa, o_fb} = '0;
    task automatic send(input logic [31:0] ins, pc, a, b, input logic [63:0] fa, fb);
        @(posedge i_clk) #1;
        {o_issue, o_instr, o_pc, o_a, o_b, o_fa, o_fb} = {1'b1, ins, pc, a, b, fa, fb};
        @(posedge i_clk) #1;
        // inverted leftovers, pc excepted, so a stale operand cannot pass
        {o_issue, o_instr, o_a, o_b, o_fa, o_fb} = {1'b0, ~ins, ~a, ~b, ~fa, ~fb};
    endtask
endmodule // aaeu_pipe_model
`default_nettype wire

//--- test_aaeu_exec.sv
// self-checking bench for the add and absolute-value execute unit
`timescale 1ns/1ps
`default_nettype none
`include "aaeu_defines.vh"
module test_aaeu_exec;
    logic i_clk = 0, i_arst_n = 0, i_ce = 1, i_issue, i_release6 = 0, i_fpu_enable = 1, i_flags_wr = 0;
    logic i_float_register_model = 1, i_ieee2008_capability = 1, i_abs_nonarith_control = 0;
    logic [1:0]  i_round_mode = 0;
    logic [4:0]  i_fp_trap_enable = 0, i_flags_data = 0, o_gr_idx, o_fr_idx, o_flags;
    logic [31:0] i_instr, i_pc, i_src_a, i_src_b, o_gr_data, a, b, x;
    logic [63:0] i_fsrc_a, i_fsrc_b, o_fr_data;
    logic        o_gr_we, o_fr_we, o_done;
    logic [2:0]  o_exc;
    logic [5:0]  o_cause;
    logic [32:0] s;
    int errors = 0, checks_done = 0, seed = 63, cyc = 0;
    aaeu_exec DUT (.*);
    aaeu_pipe_model pipe (.i_clk(i_clk), .o_issue(i_issue), .o_instr(i_instr), .o_pc(i_pc),
        .o_a(i_src_a), .o_b(i_src_b), .o_fa(i_fsrc_a), .o_fb(i_fsrc_b));
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) if (++cyc == 2000) begin errors++; end_of_test(); end
    task automatic chk(input string n, input logic [63:0] e, g);
        checks_done++;
        if (g !== e) begin errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
    endtask
    task automatic gres(input logic [2:0] e, input logic w, input logic [31:0] d);
        chk("exc", e, o_exc); chk("done", 1, o_done); chk("gr_we", w, o_gr_we);
        if (w) begin chk("gr_idx", 3, o_gr_idx); chk("gr_data", d, o_gr_data); end
    endtask
    task automatic fop(input logic [4:0] f, input logic [5:0] fn, input logic [63:0] fa, fb, r,
                       input logic [2:0] e, input logic [5:0] c);
        pipe.send({`AAEU_OP_FLOAT, f, fn == `AAEU_FN_FABS ? `AAEU_FT_ZERO : 5'h02, 5'h01, 5'h04, fn}, 0, 0, 0, fa, fb);
        chk("exc", e, o_exc); chk("cause", c, o_cause); chk("fr_we", e == 0, o_fr_we);
        if (e == 0) begin chk("fr_data", r, o_fr_data); chk("fr_idx", 4, o_fr_idx); end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_arst_n = 1;
        for (int k = 0; k < 40; k++) begin
            a = k ? $random(seed) : 32'h7FFFFFFF;
            b = k ? $random(seed) : 32'h00000001;
            s = {a[31], a} + {b[31], b};
            pipe.send({`AAEU_OP_REGISTER, 5'h01, 5'h02, 5'h03, `AAEU_SHAMT_ZERO, `AAEU_FN_REG_ADD}, 0, a, b, 0, 0);
            gres({2'h0, s[32] ^ s[31]}, s[32] == s[31], s[31:0]);
            i_release6 = k[0];
            x = {{16{b[15]}}, b[15:0]};
            s = {a[31], a} + {x[31], x};
            pipe.send({`AAEU_OP_IMM_TRAP, 5'h01, 5'h03, b[15:0]}, 0, a, b, 0, 0);
            if (k[0]) gres(`AAEU_EXC_RESERVD, 0, 0);
            else gres({2'h0, s[32] ^ s[31]}, s[32] == s[31], s[31:0]);
            pipe.send({`AAEU_OP_IMM_MOD, 5'h01, 5'h03, b[15:0]}, 0, a, b, 0, 0);
            gres(0, 1, a + x);
            pipe.send({`AAEU_OP_PC_RELATIVE_MAJOR_OPCODE, 5'h03, `AAEU_PCSUB_ADD, b[18:0]}, a, 0, 0, 0, 0);
            x = a + {{11{b[18]}}, b[18:0], 2'h0};
            gres(k[0] ? 3'h0 : `AAEU_EXC_RESERVD, k[0], x);
        end
        i_release6 = 0;
        fop(`AAEU_FMT_DOUBLE, `AAEU_FN_FADD, 64'h3FF0000000000000, 64'h3FF0000000000000,
            64'h4000000000000000, 0, 0);
        for (int m = 0; m < 4; m++) begin
            i_round_mode = m;
            fop(`AAEU_FMT_SINGLE, `AAEU_FN_FADD, 64'h3F800000, 64'h33800000,
                m == 2 ? 64'h3F800001 : 64'h3F800000, 0, 6'h01);
        end
        chk("flags", 5'h01, o_flags);
        @(posedge i_clk) #1 i_flags_wr = 1;
        @(posedge i_clk) #1 i_flags_wr = 0;
        i_fp_trap_enable = 5'h01;
        fop(`AAEU_FMT_SINGLE, `AAEU_FN_FADD, 64'h3F800000, 64'h33800000, 0, `AAEU_EXC_FLOAT, 6'h01);
        chk("flags", 5'h00, o_flags);
        i_fp_trap_enable = 0;
        fop(`AAEU_FMT_SINGLE, `AAEU_FN_FABS, 64'hFFC00000, 0, 64'h7FC00000, 0, 6'h10);
        fop(`AAEU_FMT_SINGLE, `AAEU_FN_FADD, 64'h3F800000, 64'h33800000, 64'h3F800000, 0, 6'h01);
        chk("flags", 5'h11, o_flags);
        i_abs_nonarith_control = 1;
        fop(`AAEU_FMT_SINGLE, `AAEU_FN_FABS, 64'hFFC00000, 0, 64'h7FC00000, 0, 6'h01);
        // without 2008 capability the control is ignored and abs stays arithmetic
        i_ieee2008_capability = 0;
        fop(`AAEU_FMT_SINGLE, `AAEU_FN_FABS, 64'hFFC00000, 0, 64'h7FC00000, 0, 6'h10);
        i_ieee2008_capability = 1;
        i_abs_nonarith_control = 0;
        fop(`AAEU_FMT_PAIRED, `AAEU_FN_FABS, {32'hBF800000, 32'hFFC00000}, 0,
            {32'h3F800000, 32'h7FC00000}, 0, 6'h10);
        fop(`AAEU_FMT_PAIRED, `AAEU_FN_FADD, {2{32'h3F800000}}, {32'h3F800000, 32'h33800000},
            {32'h40000000, 32'h3F800000}, 0, 6'h01);
        i_release6 = 1;
        fop(`AAEU_FMT_PAIRED, `AAEU_FN_FADD, 0, 0, 0, `AAEU_EXC_RESERVD, 6'h01);
        i_release6 = 0;
        i_fpu_enable = 0;
        fop(`AAEU_FMT_SINGLE, `AAEU_FN_FADD, 0, 0, 0, `AAEU_EXC_COP_UNU, 6'h01);
        i_fpu_enable = 1;
        i_float_register_model = 0;
        fop(`AAEU_FMT_PAIRED, `AAEU_FN_FADD, 0, 0, 0, `AAEU_EXC_FLOAT, 6'h20);
        end_of_test();
    end
endmodule // test_aaeu_exec
bind aaeu_exec aaeu_exec_monitor u_monitor (.*);
`default_nettype wire
